// ### test/sbrg_masters_model.sv
// partner model: secondary bus masters that answer a grant with a frame
module sbrg_masters_model (
  input wire logic clk_in,
  input wire logic [5:0] want_in,
  input wire logic answer_in,
  input wire logic [5:0] grant_in,
  output logic [5:0] request_out,
  output logic frame_n_out,
  output logic irdy_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  assign request_out = want_in;
  assign irdy_n_out = frame_n_out;
  initial frame_n_out = 1'b1;
  // a granted master opens its frame on the next clock, well inside the limit
  always @(posedge clk_in) frame_n_out <= !(answer_in && (|grant_in) && frame_n_out);
endmodule : sbrg_masters_model

// ### test/sbrg_request_gating_assertions.sv
// port checker for the request gating block
module sbrg_request_gating_assertions
  import sbrg_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic fundamental_reset_n_in,
  input wire logic global_reset_n_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic [7:0] cfg_rdata_out,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  input wire logic master0_grant_out,
  input wire logic master1_grant_out,
  input wire logic master2_grant_out,
  input wire logic master3_grant_out,
  input wire logic master4_grant_out,
  input wire logic master5_grant_out
);
  logic [5:0] g;
  logic ok;
  assign g = {master5_grant_out, master4_grant_out, master3_grant_out, master2_grant_out,
    master1_grant_out, master0_grant_out};
  assign ok = fundamental_reset_n_in && global_reset_n_in;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_one_grant: assert property ($onehot0(g)) else $error("two grants");
  a_frame_ends: assert property (|g && !frame_n_in && ok |=> g == 6'h00)
    else $error("grant kept");
  a_idle_grant: assert property ($rose(|g) |-> $past(frame_n_in && irdy_n_in))
    else $error("grant on busy bus");
  a_bad_addr: assert property (cfg_rd_in && ok && cfg_addr_in != SBRG_GATE_OFFSET
    && cfg_addr_in != SBRG_TOSTAT_OFFSET |=> cfg_rdata_out == 8'h00) else $error("bad read");
  a_rsvd_zero: assert property (cfg_rd_in && cfg_addr_in == SBRG_TOSTAT_OFFSET
    |=> cfg_rdata_out[7:6] == 2'h0) else $error("reserved set");
  a_rdata_hold: assert property (!cfg_rd_in && ok |=> $stable(cfg_rdata_out))
    else $error("read data moved");
  a_sync_clear: assert property (!ok |=> g == 6'h00 && cfg_rdata_out == 8'h00)
    else $error("not cleared");
  a_ctrl_back: assert property (cfg_wr_in && ok && cfg_addr_in == SBRG_GATE_OFFSET
    ##1 cfg_rd_in && ok && cfg_addr_in == SBRG_GATE_OFFSET
    |=> cfg_rdata_out[7:6] == $past(cfg_wdata_in[7:6], 2)) else $error("bad readback");
endmodule : sbrg_request_gating_assertions
bind sbrg_request_gating sbrg_request_gating_assertions i_sbrg_request_gating_assertions (.*);

// ### test/sbrg_request_gating_test.sv
// self-checking bench for the request gating block
module sbrg_request_gating_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sbrg_pkg::*;
  logic sys_clk_in = 0, rst_n_in = 0, fnd_n = 1, glb_n = 1, wr = 0, rd = 0, ans = 0;
  logic [7:0] a = 0, wd = 0, rq, d;
  logic [5:0] want = 0, tier = 0, req, g;
  logic fr_n, ir_n;
  int n_mismatch = 0, n_compared = 0, cyc = 0, hi;
  sbrg_request_gating i_sbrg_request_gating (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .fundamental_reset_n_in(fnd_n), .global_reset_n_in(glb_n), .cfg_addr_in(a),
    .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_wdata_in(wd), .cfg_rdata_out(rq),
    .master0_request_in(req[0]), .master1_request_in(req[1]), .master2_request_in(req[2]),
    .master3_request_in(req[3]), .master4_request_in(req[4]), .master5_request_in(req[5]),
    .master_high_tier_in(tier), .frame_n_in(fr_n), .irdy_n_in(ir_n),
    .master0_grant_out(g[0]), .master1_grant_out(g[1]), .master2_grant_out(g[2]),
    .master3_grant_out(g[3]), .master4_grant_out(g[4]), .master5_grant_out(g[5]));
  sbrg_masters_model i_sbrg_masters_model (.clk_in(sys_clk_in), .want_in(want),
    .answer_in(ans), .grant_in(g), .request_out(req), .frame_n_out(fr_n), .irdy_n_out(ir_n));
  initial forever #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 1500) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : step
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] v);
    a = ad;
    wd = v;
    wr = 1;
    step(1);
    wr = 0;
    step(1);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] ad);
    a = ad;
    rd = 1;
    step(1);
    rd = 0;
    step(1);
    d = rq;
  endtask : rd_reg
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic t_mask;
    ans = 1;
    for (int n = 0; n < SBRG_MASTERS; n++) begin
      wr_reg(SBRG_GATE_OFFSET, 8'(1 << n));
      want = 6'(1 << n);
      step(4);
      check({2'h0, g}, 8'h00);
      wr_reg(SBRG_GATE_OFFSET, 8'h00);
      check({2'h0, g}, 8'(1 << n));
      want = 6'h00;
      step(4);
    end
  endtask : t_mask
  task automatic t_timeout;
    ans = 0;
    wr_reg(SBRG_GATE_OFFSET, 8'hC0);
    want = 6'h04;
    for (int c = 0; c < 4 && g === 6'h00; c++) step(1);
    for (hi = 0; g === 6'h04 && hi < 40; hi++) step(1);
    check(8'(hi), 8'(SBRG_TIMEOUT_PCI_CLKS));
    step(3);
    check({2'h0, g}, 8'h00);
    rd_reg(SBRG_TOSTAT_OFFSET);
    check(d, 8'h04);
    rd_reg(SBRG_GATE_OFFSET);
    check(d, 8'hC4);
    wr_reg(SBRG_TOSTAT_OFFSET, 8'h04);
    rd_reg(SBRG_TOSTAT_OFFSET);
    check(d, 8'h00);
    wr_reg(SBRG_GATE_OFFSET, 8'h80);
    step(22);
    rd_reg(SBRG_GATE_OFFSET);
    check(d, 8'h80);
    want = 6'h00;
  endtask : t_timeout
  task automatic t_sync;
    for (int k = 0; k < 2; k++) begin
      wr_reg(SBRG_GATE_OFFSET, 8'hC5);
      fnd_n = (k != 0);
      glb_n = (k == 0);
      step(1);
      fnd_n = 1;
      glb_n = 1;
      rd_reg(SBRG_GATE_OFFSET);
      check(d, SBRG_GATE_RESET);
    end
    want = 6'h01;
    step(30);
    check({2'h0, g}, 8'h01);
    rd_reg(SBRG_TOSTAT_OFFSET);
    check(d, 8'h00);
  endtask : t_sync
  // write then read on the next edge, then write and read on one edge
  task automatic t_back;
    a = SBRG_GATE_OFFSET;
    wd = 8'h80;
    wr = 1;
    step(1);
    wr = 0;
    rd = 1;
    step(1);
    rd = 0;
    step(1);
    check(rq, 8'h80);
    wd = 8'h00;
    wr = 1;
    rd = 1;
    step(1);
    wr = 0;
    rd = 0;
    step(1);
    check(rq, 8'h80);
    rd_reg(SBRG_GATE_OFFSET);
    check(d, 8'h00);
  endtask : t_back
  // masters 0 and 1 high tier, all six requesting: expected grant order
  task automatic t_tier;
    logic [63:0] order;
    order = 64'h0104_0208_0110_0220;
    want = 6'h00;
    tier = 6'h03;
    fnd_n = 0;
    step(1);
    fnd_n = 1;
    ans = 1;
    want = 6'h3F;
    for (int i = 0; i < 8; i++) begin
      for (int c = 0; c < 8 && g === 6'h00; c++) step(1);
      check({2'h0, g}, order[63-8*i -: 8]);
      for (int c = 0; c < 8 && g !== 6'h00; c++) step(1);
    end
    want = 6'h00;
    ans = 0;
    step(4);
  endtask : t_tier
  initial begin
    step(6);
    rst_n_in = 1;
    step(1);
    rd_reg(SBRG_GATE_OFFSET);
    check(d, SBRG_GATE_RESET);
    rd_reg(8'hDC);
    check(d, 8'h00);
    wr_reg(SBRG_GATE_OFFSET, 8'h3F);
    rd_reg(SBRG_GATE_OFFSET);
    check(d, 8'h3F);
    t_back();
    t_mask();
    t_timeout();
    t_sync();
    t_tier();
    end_sim();
  end
endmodule : sbrg_request_gating_test

// ### verilog/sbrg_pkg.sv
// constants for the secondary bus request gating block
package sbrg_pkg;
  localparam int SBRG_MASTERS = 6;
  localparam logic [7:0] SBRG_GATE_OFFSET = 8'hDD;
  localparam logic [7:0] SBRG_TOSTAT_OFFSET = 8'hDE;
  localparam logic [7:0] SBRG_GATE_RESET = 8'h00;
  localparam logic [7:0] SBRG_TOSTAT_RESET = 8'h00;
  localparam int SBRG_TIMEOUT_EN_BIT = 7;
  localparam int SBRG_AUTO_MASK_BIT = 6;
  localparam int SBRG_IGNORE_LSB = 0;
  localparam int SBRG_TIMEOUT_PCI_CLKS = 16;
  localparam int SBRG_TIMEOUT_CYCLES = SBRG_TIMEOUT_PCI_CLKS;
  localparam int SBRG_CNT_W = 5;
  localparam logic [SBRG_CNT_W-1:0] SBRG_TIMEOUT_LIMIT = 5'(SBRG_TIMEOUT_CYCLES);

  typedef enum logic [2:0] {
    SBRG_ST_IDLE = 3'b001,
    SBRG_ST_GRANTED = 3'b010,
    SBRG_ST_BUSY = 3'b100
  } sbrg_state_t;
endpackage : sbrg_pkg

// ### verilog/sbrg_request_gating.sv
// secondary bus request gating, grant time-out and grant sequencing
// What this block does
// - time-out checking only while bit 7 is one; reset value zero, no time-outs.
// - count clocks from bus idle; no FRAME within 16 clocks means non-responsive.
// - with bit 6 one, a time-out masks the offender's request automatically.
// - mask bits 5..0 make the arbiter ignore request inputs 5..0 when one.
// - eight-bit gating register read and written at configuration offset DDh.
// - gating register returns to 00h on fundamental, global or power-on reset.
// - each time-out sets a per-request flag, read and cleared at offset DEh.
// - gated requests are arbitrated two-tier rotationally, high or low tier each.
module sbrg_request_gating
  import sbrg_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic fundamental_reset_n_in,
  input wire logic global_reset_n_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  input wire logic master0_request_in,
  input wire logic master1_request_in,
  input wire logic master2_request_in,
  input wire logic master3_request_in,
  input wire logic master4_request_in,
  input wire logic master5_request_in,
  input wire logic [SBRG_MASTERS-1:0] master_high_tier_in,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  output logic master0_grant_out,
  output logic master1_grant_out,
  output logic master2_grant_out,
  output logic master3_grant_out,
  output logic master4_grant_out,
  output logic master5_grant_out
);
  logic [7:0] gate_ff;
  logic [7:0] nxt_gate;
  logic [SBRG_MASTERS-1:0] tostat_ff;
  logic [SBRG_MASTERS-1:0] nxt_tostat;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  sbrg_state_t state_ff;
  sbrg_state_t nxt_state;
  logic [SBRG_MASTERS-1:0] grant_ff;
  logic [SBRG_MASTERS-1:0] nxt_grant;
  logic [SBRG_CNT_W-1:0] cnt_ff;
  logic [SBRG_CNT_W-1:0] nxt_cnt;
  logic sync_clear;
  logic bus_idle;
  logic grant_timeout_enable;
  logic auto_mask;
  logic timeout_hit;
  logic advance;
  logic [SBRG_MASTERS-1:0] raw_req;
  logic [SBRG_MASTERS-1:0] ignore;
  logic [SBRG_MASTERS-1:0] gated_req;
  logic [SBRG_MASTERS-1:0] winner;
  logic [SBRG_MASTERS-1:0] timeout_set;
  logic gate_wr;
  logic tostat_wr;

  assign sync_clear = !fundamental_reset_n_in || !global_reset_n_in;
  assign bus_idle = frame_n_in && irdy_n_in;
  assign grant_timeout_enable = gate_ff[SBRG_TIMEOUT_EN_BIT];
  assign auto_mask = gate_ff[SBRG_AUTO_MASK_BIT];
  assign ignore = gate_ff[SBRG_IGNORE_LSB +: SBRG_MASTERS];
  assign raw_req = {master5_request_in, master4_request_in, master3_request_in,
                    master2_request_in, master1_request_in, master0_request_in};
  assign gated_req = raw_req & ~ignore;
  assign gate_wr = cfg_wr_in && (cfg_addr_in == SBRG_GATE_OFFSET);
  assign tostat_wr = cfg_wr_in && (cfg_addr_in == SBRG_TOSTAT_OFFSET);

  sbrg_rotate_arbiter #(
    .N(SBRG_MASTERS)
  ) i_sbrg_rotate_arbiter (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .sync_clear_in(sync_clear),
    .request_in(gated_req),
    .high_tier_in(master_high_tier_in),
    .advance_in(advance),
    .winner_out(winner)
  );

  // grant sequencing and time-out detection
  always_comb begin
    nxt_state = state_ff;
    nxt_grant = grant_ff;
    nxt_cnt = cnt_ff;
    timeout_hit = 1'b0;
    advance = 1'b0;
    unique case (state_ff)
      SBRG_ST_IDLE: begin
        nxt_cnt = '0;
        if (bus_idle && winner != '0) begin
          nxt_grant = winner;
          advance = 1'b1;
          nxt_state = SBRG_ST_GRANTED;
        end
      end
      SBRG_ST_GRANTED: begin
        if (!frame_n_in) begin
          nxt_grant = '0;
          nxt_state = SBRG_ST_BUSY;
        end else if ((grant_ff & gated_req) == '0) begin
          nxt_grant = '0;
          nxt_state = SBRG_ST_IDLE;
        end else if (bus_idle && grant_timeout_enable) begin
          nxt_cnt = cnt_ff + 5'h01;
          // FRAME still high on the sixteenth idle clock: master presumed dead
          if (nxt_cnt == SBRG_TIMEOUT_LIMIT) begin
            timeout_hit = 1'b1;
            nxt_grant = '0;
            nxt_state = SBRG_ST_IDLE;
          end
        end
      end
      SBRG_ST_BUSY: begin
        if (bus_idle) begin
          nxt_state = SBRG_ST_IDLE;
        end
      end
      default: begin
        nxt_state = SBRG_ST_IDLE;
        nxt_grant = '0;
      end
    endcase
    if (sync_clear) begin
      nxt_state = SBRG_ST_IDLE;
      nxt_grant = '0;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= SBRG_ST_IDLE;
      grant_ff <= '0;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      grant_ff <= nxt_grant;
      cnt_ff <= nxt_cnt;
    end
  end

  // configuration registers; hardware set wins over a same-cycle software clear
  always_comb begin
    timeout_set = timeout_hit ? grant_ff : '0;
    nxt_gate = gate_ff;
    if (gate_wr) begin
      nxt_gate = cfg_wdata_in;
    end
    if (auto_mask) begin
      nxt_gate[SBRG_IGNORE_LSB +: SBRG_MASTERS] =
        nxt_gate[SBRG_IGNORE_LSB +: SBRG_MASTERS] | timeout_set;
    end
    nxt_tostat = tostat_ff;
    if (tostat_wr) begin
      nxt_tostat = tostat_ff & ~cfg_wdata_in[SBRG_MASTERS-1:0];
    end
    nxt_tostat = nxt_tostat | timeout_set;
    nxt_rdata = rdata_ff;
    if (cfg_rd_in) begin
      if (cfg_addr_in == SBRG_GATE_OFFSET) begin
        nxt_rdata = gate_ff;
      end else if (cfg_addr_in == SBRG_TOSTAT_OFFSET) begin
        nxt_rdata = {2'h0, tostat_ff};
      end else begin
        nxt_rdata = 8'h00;
      end
    end
    if (sync_clear) begin
      nxt_gate = SBRG_GATE_RESET;
      nxt_tostat = SBRG_TOSTAT_RESET[SBRG_MASTERS-1:0];
      nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_ff <= SBRG_GATE_RESET;
      tostat_ff <= SBRG_TOSTAT_RESET[SBRG_MASTERS-1:0];
      rdata_ff <= 8'h00;
    end else begin
      gate_ff <= nxt_gate;
      tostat_ff <= nxt_tostat;
      rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_rdata_out = rdata_ff;
  assign master0_grant_out = grant_ff[0];
  assign master1_grant_out = grant_ff[1];
  assign master2_grant_out = grant_ff[2];
  assign master3_grant_out = grant_ff[3];
  assign master4_grant_out = grant_ff[4];
  assign master5_grant_out = grant_ff[5];
endmodule : sbrg_request_gating

// ### verilog/sbrg_rotate_arbiter.sv
// two-tier rotational pick among gated requests
module sbrg_rotate_arbiter
  import sbrg_pkg::*;
#(
  parameter int N = SBRG_MASTERS
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic sync_clear_in,
  input wire logic [N-1:0] request_in,
  input wire logic [N-1:0] high_tier_in,
  input wire logic advance_in,
  output logic [N-1:0] winner_out
);
  logic [N-1:0] last_hi_ff;
  logic [N-1:0] last_lo_ff;
  logic low_turn_ff;
  logic [N-1:0] nxt_last_hi;
  logic [N-1:0] nxt_last_lo;
  logic nxt_low_turn;
  logic [N-1:0] pick_hi;
  logic [N-1:0] pick_lo;

  // first requester strictly after the last winner, wrapping around
  function automatic logic [N-1:0] rr_pick(input logic [N-1:0] req, input logic [N-1:0] last);
    logic [N-1:0] res;
    int start;
    int idx;
    res = '0;
    start = 0;
    for (int i = 0; i < N; i++) begin
      if (last[i]) begin
        start = i + 1;
      end
    end
    for (int k = N - 1; k >= 0; k--) begin
      idx = (start + k) % N;
      if (req[idx]) begin
        res = '0;
        res[idx] = 1'b1;
      end
    end
    return res;
  endfunction : rr_pick

  always_comb begin
    pick_hi = rr_pick(request_in & high_tier_in, last_hi_ff);
    pick_lo = rr_pick(request_in & ~high_tier_in, last_lo_ff);
    // low tier takes one slot after each high-tier grant so it never starves
    if (pick_lo != '0 && (pick_hi == '0 || low_turn_ff)) begin
      winner_out = pick_lo;
    end else begin
      winner_out = pick_hi;
    end
    nxt_last_hi = last_hi_ff;
    nxt_last_lo = last_lo_ff;
    nxt_low_turn = low_turn_ff;
    if (advance_in && winner_out != '0) begin
      if ((winner_out & high_tier_in) != '0) begin
        nxt_last_hi = winner_out;
        nxt_low_turn = 1'b1;
      end else begin
        nxt_last_lo = winner_out;
        nxt_low_turn = 1'b0;
      end
    end
    if (sync_clear_in) begin
      nxt_last_hi = '0;
      nxt_last_lo = '0;
      nxt_low_turn = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_hi_ff <= '0;
      last_lo_ff <= '0;
      low_turn_ff <= 1'b0;
    end else begin
      last_hi_ff <= nxt_last_hi;
      last_lo_ff <= nxt_last_lo;
      low_turn_ff <= nxt_low_turn;
    end
  end
endmodule : sbrg_rotate_arbiter
